// ==== hdl/rbw_boot_words.sv ====
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "rbw_regs.svh"
module rbw_boot_words
  import rbw_pkg::*;
#(
  parameter logic [3:0] Z_BANK_EXT = 4'h0,
  parameter logic [3:0] STACK_BANK_EXT = 4'h0,
  parameter logic [3:0] PROG_BANK_EXT = 4'h0,
  parameter logic [15:0] PROG_COUNTER = 16'h0000,
  parameter logic [15:0] STACK_POINTER = 16'h0000,
  parameter logic [15:0] Z_INDEX = 16'h0000
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire rbw_apb_req_t apb_req,
  output rbw_apb_rsp_t apb_rsp,
  input wire logic boot_sel_n,
  input wire rbw_vec_req_t vec_req,
  output rbw_vec_rsp_t vec_rsp
);
  // mask-time contents are constants: no storage, so nothing can write them
  localparam logic [15:0] BANK_WORD = {4'h0, Z_BANK_EXT, STACK_BANK_EXT, PROG_BANK_EXT};

  logic coded_q;
  logic coded_d;
  logic boot_low_q;
  logic ack_q;
  logic ack_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic err_q;
  logic err_d;
  logic vhit_q;
  logic vhit_d;
  logic [15:0] vdata_q;
  logic [15:0] vdata_d;
  logic [15:0] w0;
  logic [15:0] w1;
  logic [15:0] w2;
  logic [15:0] w3;

  // blank parts read zero until software marks the rom as coded
  rbw_word_slot #(
    .MASK_WORD(BANK_WORD)
  ) u_slot0 (
    .coded(coded_q),
    .word(w0)
  );

  rbw_word_slot #(
    .MASK_WORD(PROG_COUNTER)
  ) u_slot1 (
    .coded(coded_q),
    .word(w1)
  );

  rbw_word_slot #(
    .MASK_WORD(STACK_POINTER)
  ) u_slot2 (
    .coded(coded_q),
    .word(w2)
  );

  rbw_word_slot #(
    .MASK_WORD(Z_INDEX)
  ) u_slot3 (
    .coded(coded_q),
    .word(w3)
  );

  // boot select is a pin: three flops, change taken when last two agree
  rbw_pin_sync u_boot_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_n(boot_sel_n),
    .low_q(boot_low_q)
  );

  // apb decode
  wire logic [11:0] a = apb_req.paddr;
  wire logic setup = apb_req.psel && !apb_req.penable;
  // access edge: the one at which the master samples pready high
  wire logic access = apb_req.psel && apb_req.penable && ack_q;
  wire logic hit_w0 = a == `RBW_OFF_BANK_EXT;
  wire logic hit_w1 = a == `RBW_OFF_PC;
  wire logic hit_w2 = a == `RBW_OFF_SP;
  wire logic hit_w3 = a == `RBW_OFF_IZ;
  wire logic hit_ctrl = a == `RBW_OFF_CTRL;
  wire logic hit_stat = a == `RBW_OFF_STAT;
  wire logic hit_word = hit_w0 || hit_w1 || hit_w2 || hit_w3;
  wire logic mapped = hit_word || hit_ctrl || hit_stat;
  // only ctrl has storage; writes to the words are accepted and dropped
  wire logic wr_ctrl = access && apb_req.pwrite && hit_ctrl;

  // read sources, upper half zero for the 16-bit words
  wire logic [31:0] rd_w0 = {16'h0000, w0};
  wire logic [31:0] rd_w1 = {16'h0000, w1};
  wire logic [31:0] rd_w2 = {16'h0000, w2};
  wire logic [31:0] rd_w3 = {16'h0000, w3};
  wire logic [31:0] rd_ctrl = {31'h0000_0000, coded_q};
  wire logic [31:0] rd_stat = {31'h0000_0000, boot_low_q};
  wire logic [31:0] rd_mux =
    hit_w0 ? rd_w0 :
    hit_w1 ? rd_w1 :
    hit_w2 ? rd_w2 :
    hit_w3 ? rd_w3 :
    hit_ctrl ? rd_ctrl :
    hit_stat ? rd_stat : 32'h0000_0000;

  // no wait state: answer in the cycle after setup
  assign coded_d = wr_ctrl ? apb_req.pwdata[0] : coded_q;
  assign ack_d = setup;
  assign rdata_d = setup ? rd_mux : 32'h0000_0000;
  assign err_d = setup && !mapped;

  // vector window: only even addresses zero..six
  wire logic vec_hi_ok = vec_req.addr <= `RBW_VEC_HI;
  wire logic vec_even = !vec_req.addr[0];
  wire logic vec_in = vec_hi_ok && vec_even;
  wire logic vec_take = vec_req.valid && vec_in && coded_q && boot_low_q;
  wire logic [1:0] vec_idx = vec_req.addr[2:1];
  wire logic [15:0] vec_mux =
    vec_idx == 2'h0 ? w0 :
    vec_idx == 2'h1 ? w1 :
    vec_idx == 2'h2 ? w2 : w3;
  assign vhit_d = vec_take;
  // data is zero outside a hit so a stale word never leaks
  assign vdata_d = vec_take ? vec_mux : 16'h0000;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      coded_q <= 1'b0;
    end else begin
      coded_q <= coded_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      err_q <= 1'b0;
    end else begin
      err_q <= err_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      vhit_q <= 1'b0;
    end else begin
      vhit_q <= vhit_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      vdata_q <= 16'h0000;
    end else begin
      vdata_q <= vdata_d;
    end
  end

  assign apb_rsp.prdata = rdata_q;
  assign apb_rsp.pready = ack_q;
  assign apb_rsp.pslverr = err_q;
  assign vec_rsp.hit = vhit_q;
  assign vec_rsp.data = vdata_q;
endmodule : rbw_boot_words

// one mask-time word, forced to the blank value on an uncoded part
module rbw_word_slot #(
  parameter logic [15:0] MASK_WORD = 16'h0000
) (
  input wire logic coded,
  output logic [15:0] word
);
  assign word = coded ? MASK_WORD : `RBW_BLANK_WORD;
endmodule : rbw_word_slot

// three-flop pin synchroniser; level taken once the last two flops agree
module rbw_pin_sync (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic pin_n,
  output logic low_q
);
  logic [2:0] sync_q;
  logic [2:0] sync_d;
  logic low_d;
  wire logic agree = sync_q[1] == sync_q[2];
  assign sync_d = {sync_q[1:0], pin_n};
  assign low_d = agree ? !sync_q[2] : low_q;

  // reset to the inactive level so reset alone never looks like boot low
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync_q <= 3'h7;
    end else begin
      sync_q <= sync_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      low_q <= 1'b0;
    end else begin
      low_q <= low_d;
    end
  end
endmodule : rbw_pin_sync

// ==== pkg/rbw_regs.svh ====
`ifndef RBW_REGS_SVH
`define RBW_REGS_SVH
// register byte offsets on the apb slave
`define RBW_OFF_BANK_EXT 12'h0830
`define RBW_OFF_PC 12'h0832
`define RBW_OFF_SP 12'h0834
`define RBW_OFF_IZ 12'h0836
// control/status registers placed after the bootstrap words
`define RBW_OFF_CTRL 12'h0840
`define RBW_OFF_STAT 12'h0844
// vector fetch addresses
`define RBW_VEC_LO 20'h0_0000
`define RBW_VEC_HI 20'h0_0006
// word 0 field positions
`define RBW_ZK_LSB 8
`define RBW_SK_LSB 4
`define RBW_PK_LSB 0
`define RBW_FIELD_W 4
// ctrl reset value: bit0 = customer code masked
`define RBW_CTRL_RST 32'h0000_0000
`define RBW_BLANK_WORD 16'h0000
`endif

// ==== pkg/rbw_pkg.sv ====
package rbw_pkg;
  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } rbw_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rbw_apb_rsp_t;
  typedef struct packed {
    logic valid;
    logic [19:0] addr;
  } rbw_vec_req_t;
  typedef struct packed {
    logic hit;
    logic [15:0] data;
  } rbw_vec_rsp_t;
endpackage : rbw_pkg

// ==== testbench/rbw_core_model.sv ====
`timescale 1ns/1ps
module rbw_core_model
  import rbw_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [19:0] addr,
  output rbw_vec_req_t vec_req
);
  // idle address is inverted so a stale fetch address never looks valid
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n) vec_req <= '0;
    else vec_req <= '{go, go ? addr : ~addr};
endmodule : rbw_core_model

// ==== testbench/rbw_boot_words_props.sv ====
`timescale 1ns/1ps
`include "rbw_regs.svh"
module rbw_boot_words_props
  import rbw_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire rbw_apb_req_t apb_req,
  input wire rbw_apb_rsp_t apb_rsp,
  input wire rbw_vec_req_t vec_req,
  input wire rbw_vec_rsp_t vec_rsp
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic coded_q;
  wire wd = apb_rsp.pready && apb_req.paddr[11:3] == 9'h106 && !apb_req.paddr[0];
  wire rd = wd && !apb_req.pwrite;
  wire set = apb_rsp.pready && apb_req.pwrite && apb_req.paddr == `RBW_OFF_CTRL;
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n) coded_q <= 1'b0;
    else if (set) coded_q <= apb_req.pwdata[0];
  property p_blank; rd && !coded_q |-> apb_rsp.prdata == 32'h0000_0000; endproperty
  a_blank: assert property (p_blank) else $error("blank word not zero");
  property p_hi; rd |-> apb_rsp.prdata[31:16] == 16'h0000 && !apb_rsp.pslverr; endproperty
  a_hi: assert property (p_hi) else $error("word read bad");
  property p_wr; wd && apb_req.pwrite |-> !apb_rsp.pslverr; endproperty
  a_wr: assert property (p_wr) else $error("word write refused");
  property p_hit;
    vec_rsp.hit |-> coded_q && $past(vec_req.valid) && !$past(vec_req.addr[0])
      && $past(vec_req.addr) <= 20'h0_0006;
  endproperty
  a_hit: assert property (p_hit) else $error("bad vector hit");
  property p_w0; vec_rsp.hit && $past(vec_req.addr) == 20'h0_0000 |-> !vec_rsp.data[15:12];
  endproperty
  a_w0: assert property (p_w0) else $error("word0 top bits set");
  c_hit: cover property (vec_rsp.hit);
  c_err: cover property (apb_rsp.pslverr);
  c_rd: cover property (rd && coded_q);
endmodule : rbw_boot_words_props
bind rbw_boot_words rbw_boot_words_props u_props (.clk_sys(clk_sys), .rst_n(rst_n),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .vec_req(vec_req), .vec_rsp(vec_rsp));

// ==== testbench/rbw_boot_words_bench.sv ====
`timescale 1ns/1ps
`include "rbw_regs.svh"
module rbw_boot_words_bench;
  import rbw_pkg::*;
  logic clk_sys = 0, rst_n = 0, boot_sel_n = 0, go = 0;
  logic [19:0] va = '0;
  rbw_apb_req_t rq = '0;
  rbw_apb_rsp_t rs, r;
  rbw_vec_req_t vq;
  rbw_vec_rsp_t vs;
  int failures = 0, checked = 0, seed = 74, cyc = 0;
  always #2.5 clk_sys = ~clk_sys;
  rbw_core_model core (.clk_sys(clk_sys), .rst_n(rst_n), .go(go), .addr(va), .vec_req(vq));
  rbw_boot_words #(.Z_BANK_EXT(4'h3), .STACK_BANK_EXT(4'h5),
    .PROG_COUNTER(16'h1234), .STACK_POINTER(16'h5678), .Z_INDEX(16'h9abc)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .apb_req(rq), .apb_rsp(rs), .boot_sel_n(boot_sel_n),
    .vec_req(vq), .vec_rsp(vs));
  function logic [15:0] ew(input logic [2:0] a);
    return a == 0 ? 16'h0350 : a == 2 ? 16'h1234 : a == 4 ? 16'h5678 : 16'h9abc;
  endfunction : ew
  task cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask : cmp
  task print_verdict;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys) rq <= '{a, 1'b1, 1'b0, w, d};
    @(posedge clk_sys) rq.penable <= 1'b1;
    do @(posedge clk_sys); while (rs.pready !== 1'b1);
    r = rs;
    rq <= '0;
  endtask : apb
  task fetch(input logic [3:0] a, input logic on);
    @(posedge clk_sys) go <= 1'b1;
    va <= {16'h0000, a};
    @(posedge clk_sys) go <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    on = on && !a[0] && a <= 6;
    cmp("hit", on, vs.hit);
    cmp("data", on ? ew(a[2:0]) : 16'h0000, vs.data);
  endtask : fetch
  always @(posedge clk_sys) if (++cyc == 3000) begin
    failures++;
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int p = 0; p < 3; p++) begin
      if (p == 1) apb(1'b1, `RBW_OFF_CTRL, 32'h0000_0001);
      boot_sel_n <= p == 2;
      // the boot pin passes a synchroniser, so let it settle first
      repeat (6) @(posedge clk_sys);
      for (int i = 0; i < 4; i++) begin
        apb(1'b1, 12'(`RBW_OFF_BANK_EXT + 2 * i), $random(seed));
        cmp("wr_err", 0, r.pslverr);
        apb(1'b0, 12'(`RBW_OFF_BANK_EXT + 2 * i), 32'h0000_0000);
        cmp("word", p > 0 ? ew(3'(2 * i)) : 16'h0000, r.prdata);
      end
      apb(1'b0, `RBW_OFF_STAT, 32'h0000_0000);
      cmp("stat", p != 2, r.prdata);
      apb(1'b0, `RBW_OFF_CTRL, 32'h0000_0000);
      cmp("ctrl", p > 0, r.prdata);
      for (int i = 0; i < 10; i++) fetch(4'(i < 8 ? i : $random(seed)), p == 1);
    end
    apb(1'b0, 12'h0900, 32'h0000_0000);
    cmp("err", 1, r.pslverr);
    cmp("err_data", 0, r.prdata);
    print_verdict();
  end
endmodule : rbw_boot_words_bench
